// [hw/spi_master_pkg.sv]
// Types shared by the SPI master modules.
package spi_master_pkg;

  typedef enum logic [0:0] {
    engine_idle,
    engine_shift
  } engine_state_type;

  typedef enum logic [2:0] {
    index_control,
    index_buffer,
    index_status,
    index_mask,
    index_none
  } reg_index_type;

  typedef struct packed {
    logic [7:0]       control;
    logic [7:0]       serial_buffer_reg;
    logic [7:0]       tx_shift;
    logic [7:0]       serial_shift_reg;
    logic [2:0]       status;
    logic [2:0]       mask;
    logic [4:0]       half_count;
    engine_state_type state;
    logic             sclk;
    logic             sdo;
    logic             sdo_oe;
    logic             irq;
    logic             sdi_meta;
    logic             sdi_sync;
    logic [1:0]       sample_pipe;
    logic [1:0]       done_pipe;
    logic             wr_pending;
    reg_index_type    wr_index;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic             hresp;
  } spi_state_type;

endpackage

// [hw/spi_master_regs.svh]
// Register offsets, field positions, reset values and clock divide counts of the SPI master.
`ifndef SPI_MASTER_REGS_SVH
`define SPI_MASTER_REGS_SVH

// Byte offsets on the register bus.
`define CONTROL_OFFSET        12'h000
`define BUFFER_OFFSET         12'h004
`define STATUS_OFFSET         12'h008
`define MASK_OFFSET           12'h00C

// Fields of serial_port_control_one.
`define CTRL_RATE_LSB         0
`define CTRL_RATE_MSB         1
`define CTRL_SDO_DISABLE_BIT  3
`define CTRL_POLARITY_BIT     4
`define CTRL_ENABLE_BIT       5
`define CTRL_EDGE_SELECT_BIT  6
`define CTRL_SAMPLE_PHASE_BIT 7
`define CTRL_RESET            8'h00

// Fields of the status and mask registers.
`define STAT_RX_DONE_BIT      0
`define STAT_COLLISION_BIT    1
`define STAT_OVERFLOW_BIT     2
`define STAT_BUSY_BIT         8
`define STAT_RESET            3'h0
`define MASK_RESET            3'h0

// Rate select codes.
`define RATE_DIV4             2'h0
`define RATE_DIV16            2'h1
`define RATE_DIV64            2'h2
`define RATE_TIMER            2'h3

// Half bit periods in oscillator cycles for each divided rate.
`define HALF_PERIOD_DIV4      6'h02
`define HALF_PERIOD_DIV16     6'h08
`define HALF_PERIOD_DIV64     6'h20

// Half bit ticks in one byte, also the count that holds the closing half period.
`define HALF_TICKS_BYTE       5'h10

`endif

// [hw/spi_master_transfer.sv]
// SPI master transfer engine with its AHB-Lite register slave and interrupt.
`include "spi_master_regs.svh"

// Function
// - Buffer write starts one byte exchange.
// - Master drives serial clock, starts anytime.
// - Output may be disabled; input keeps sampling.
// - Received byte copied to buffer, flags set.
// - Control bit 4 picks clock idle level.
// - Most significant bit shifted first.
// - Rate is divide 4, 16, 64, timer/2.
// - Edge select set presents data before edge.
// - Sample phase bit moves input sample point.
module spi_master_transfer #(
  parameter int DIV_WIDTH = 6
) (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Timer two output pulse.
  input  wire logic        timer_two_tick,
  // Serial pins.
  output logic             sclk,
  output logic             sdo,
  output logic             sdo_oe,
  input  wire logic        sdi,
  // Interrupt.
  output logic             irq
);

  spi_master_pkg::spi_state_type state;
  spi_master_pkg::spi_state_type next_state;

  spi_rate_if rate ();

  spi_rate_divider #(
    .DIV_WIDTH (DIV_WIDTH)
  ) divider (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .timer_two_tick (timer_two_tick),
    .rate           (rate.divider)
  );

  function automatic spi_master_pkg::reg_index_type reg_index(input logic [31:0] addr);
    case (addr[11:0])
      `CONTROL_OFFSET: reg_index = spi_master_pkg::index_control;
      `BUFFER_OFFSET:  reg_index = spi_master_pkg::index_buffer;
      `STATUS_OFFSET:  reg_index = spi_master_pkg::index_status;
      `MASK_OFFSET:    reg_index = spi_master_pkg::index_mask;
      default:         reg_index = spi_master_pkg::index_none;
    endcase
  endfunction

  logic       enable;
  logic       polarity;
  logic       edge_select;
  logic       sample_phase;
  logic       addr_phase;
  logic       odd_half;
  logic       sample_now;
  logic       present_now;
  logic       byte_done;
  logic       busy;
  logic       start;
  logic [7:0] rx_next;
  logic [2:0] status_set;
  logic [2:0] status_clear;

  assign enable       = state.control[`CTRL_ENABLE_BIT];
  assign polarity     = state.control[`CTRL_POLARITY_BIT];
  assign edge_select  = state.control[`CTRL_EDGE_SELECT_BIT];
  assign sample_phase = state.control[`CTRL_SAMPLE_PHASE_BIT];
  assign addr_phase   = hsel && htrans[1] && hready;
  assign odd_half     = state.half_count[0];

  assign rate.rate_sel = state.control[`CTRL_RATE_MSB:`CTRL_RATE_LSB];
  assign rate.run      = (state.state == spi_master_pkg::engine_shift);

  // Half ticks are numbered 0 to 16; the clock toggles on the first sixteen.
  always_comb begin
    sample_now  = 1'b0;
    present_now = 1'b0;
    if (edge_select) begin
      if (sample_phase) begin
        sample_now = odd_half;
      end else begin
        sample_now = !odd_half && (state.half_count < `HALF_TICKS_BYTE - 5'h01);
      end
      present_now = odd_half && (state.half_count < `HALF_TICKS_BYTE - 5'h02);
    end else begin
      if (sample_phase) begin
        sample_now = !odd_half && (state.half_count >= 5'h02);
      end else begin
        sample_now = odd_half;
      end
      present_now = !odd_half && (state.half_count >= 5'h02) && (state.half_count < `HALF_TICKS_BYTE);
    end
  end

  assign busy      = (state.state == spi_master_pkg::engine_shift) || (|state.done_pipe);
  assign start     = state.wr_pending && (state.wr_index == spi_master_pkg::index_buffer) && enable && !busy;
  assign byte_done = rate.half_tick && (state.state == spi_master_pkg::engine_shift) &&
                     (state.half_count == `HALF_TICKS_BYTE);

  // Input bits enter at the low end, so the first bit received ends as the most significant.
  // The strobe lags the sample point by the two synchroniser stages, so the bit taken is the pin level
  // at that point; without this the fastest rates would read the previous bit.
  assign rx_next = state.sample_pipe[1] ? {state.serial_shift_reg[6:0], state.sdi_sync} :
                   state.serial_shift_reg;

  always_comb begin
    status_set = 3'h0;
    status_set[`STAT_RX_DONE_BIT]   = state.done_pipe[1];
    status_set[`STAT_OVERFLOW_BIT]  = state.done_pipe[1] && state.status[`STAT_RX_DONE_BIT];
    status_set[`STAT_COLLISION_BIT] = state.wr_pending && (state.wr_index == spi_master_pkg::index_buffer) && busy;
    status_clear = 3'h0;
    if (state.wr_pending && (state.wr_index == spi_master_pkg::index_status)) begin
      status_clear = hwdata[2:0];
    end
  end

  always_comb begin
    next_state = state;

    // Input synchroniser; only the second stage is sampled.
    next_state.sdi_meta = sdi;
    next_state.sdi_sync = state.sdi_meta;

    // Register writes land in the data phase.
    next_state.wr_pending = 1'b0;
    if (addr_phase) begin
      next_state.wr_pending = hwrite;
      next_state.wr_index   = reg_index(haddr);
    end
    if (state.wr_pending) begin
      case (state.wr_index)
        spi_master_pkg::index_control: next_state.control = hwdata[7:0];
        spi_master_pkg::index_mask:    next_state.mask    = hwdata[2:0];
        default:                       next_state.mask    = next_state.mask;
      endcase
    end

    // A set in the same cycle as a clear wins.
    next_state.status = (state.status & ~status_clear) | status_set;

    // Delayed receive strobes line up with the synchronised input.
    next_state.sample_pipe = {state.sample_pipe[0],
                              (state.state == spi_master_pkg::engine_shift) && enable && rate.half_tick && sample_now};
    next_state.done_pipe   = {state.done_pipe[0], byte_done && enable};
    next_state.serial_shift_reg = rx_next;
    if (state.done_pipe[1]) begin
      next_state.serial_buffer_reg = rx_next;
    end

    // Serial engine.
    case (state.state)
      spi_master_pkg::engine_idle: begin
        next_state.sclk = next_state.control[`CTRL_POLARITY_BIT];
        if (start) begin
          next_state.state             = spi_master_pkg::engine_shift;
          next_state.serial_buffer_reg = hwdata[7:0];
          next_state.tx_shift          = hwdata[7:0];
          next_state.sdo               = hwdata[7];
          next_state.half_count        = 5'h00;
        end
      end
      spi_master_pkg::engine_shift: begin
        if (!enable) begin
          next_state.state = spi_master_pkg::engine_idle;
          next_state.sclk  = polarity;
        end else if (rate.half_tick) begin
          if (state.half_count < `HALF_TICKS_BYTE) begin
            next_state.sclk = !state.sclk;
          end
          if (present_now) begin
            next_state.tx_shift = {state.tx_shift[6:0], 1'b0};
            next_state.sdo      = state.tx_shift[6];
          end
          if (byte_done) begin
            next_state.state = spi_master_pkg::engine_idle;
          end else begin
            next_state.half_count = state.half_count + 5'h01;
          end
        end
      end
      default: begin
        next_state.state = spi_master_pkg::engine_idle;
      end
    endcase

    // Receive only use leaves the data pin undriven while shifting continues.
    next_state.sdo_oe = next_state.control[`CTRL_ENABLE_BIT] &&
                        !next_state.control[`CTRL_SDO_DISABLE_BIT];

    next_state.irq = |(next_state.status & next_state.mask);

    // Read data is taken from the updated values so a read right after a write sees it.
    next_state.hreadyout = 1'b1;
    next_state.hresp     = 1'b0;
    if (addr_phase && !hwrite) begin
      case (reg_index(haddr))
        spi_master_pkg::index_control: next_state.hrdata = {24'h000000, next_state.control};
        spi_master_pkg::index_buffer:  next_state.hrdata = {24'h000000, next_state.serial_buffer_reg};
        spi_master_pkg::index_status:  next_state.hrdata = {23'h000000,
                                         (next_state.state == spi_master_pkg::engine_shift) ||
                                         (|next_state.done_pipe),
                                         5'h00, next_state.status};
        spi_master_pkg::index_mask:    next_state.hrdata = {29'h00000000, next_state.mask};
        default:                       next_state.hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state           <= '0;
      state.control   <= `CTRL_RESET;
      state.status    <= `STAT_RESET;
      state.mask      <= `MASK_RESET;
      state.state     <= spi_master_pkg::engine_idle;
      state.wr_index  <= spi_master_pkg::index_none;
      state.hreadyout <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign hrdata    = state.hrdata;
  assign hreadyout = state.hreadyout;
  assign hresp     = state.hresp;
  assign sclk      = state.sclk;
  assign sdo       = state.sdo;
  assign sdo_oe    = state.sdo_oe;
  assign irq       = state.irq;

endmodule // spi_master_transfer

// [hw/spi_rate_divider.sv]
// Half bit tick generator for the SPI master clock rates.
module spi_rate_divider #(
  parameter int DIV_WIDTH = 6
) (
  // Clock and reset.
  input  wire logic   hclk,
  input  wire logic   hresetn,
  // Timer two output pulse, same clock domain.
  input  wire logic   timer_two_tick,
  // Engine side.
  spi_rate_if.divider rate
);

  typedef struct packed {
    logic [DIV_WIDTH-1:0] count;
    logic                 tick;
  } divider_state_type;

  divider_state_type state;
  divider_state_type next_state;
  logic [DIV_WIDTH-1:0] half_period;

  if (DIV_WIDTH < 6) begin : width_check
    $error("DIV_WIDTH must hold the longest half period.");
  end

  always_comb begin
    case (rate.rate_sel)
      `RATE_DIV4:  half_period = DIV_WIDTH'(`HALF_PERIOD_DIV4);
      `RATE_DIV16: half_period = DIV_WIDTH'(`HALF_PERIOD_DIV16);
      default:     half_period = DIV_WIDTH'(`HALF_PERIOD_DIV64);
    endcase
  end

  // The count restarts while stopped so the first half bit of a byte is full length.
  always_comb begin
    next_state      = state;
    next_state.tick = 1'b0;
    if (!rate.run) begin
      next_state.count = '0;
    end else if (rate.rate_sel == `RATE_TIMER) begin
      next_state.tick  = timer_two_tick;
      next_state.count = '0;
    end else if (state.count == half_period - DIV_WIDTH'(1)) begin
      next_state.tick  = 1'b1;
      next_state.count = '0;
    end else begin
      next_state.count = state.count + DIV_WIDTH'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rate.half_tick = state.tick;

endmodule // spi_rate_divider

// [hw/spi_rate_if.sv]
// Carrier between the transfer engine and its bit rate divider.
interface spi_rate_if;
  logic [1:0] rate_sel;
  logic       run;
  logic       half_tick;

  modport engine  (output rate_sel, output run, input half_tick);
  modport divider (input rate_sel, input run, output half_tick);
endinterface

// [testbench/spi_master_assertions.sv]
// Port checker of the SPI master, bound to the top module.
module spi_master_assertions (
  // Clock and reset.
  input wire logic        hclk,
  input wire logic        hresetn,
  // Register bus.
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  // Serial side and interrupt.
  input wire logic        timer_two_tick,
  input wire logic        sclk,
  input wire logic        sdo,
  input wire logic        sdo_oe,
  input wire logic        irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Control and mask are shadowed from bus writes, since the checker cannot see inside.
  logic        wr_q;
  logic [11:0] a_q;
  logic [7:0]  ctrl;
  logic [2:0]  msk;
  logic [5:0]  tog;
  wire         bw = wr_q && a_q == 12'h004;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      a_q  <= 12'h000;
      ctrl <= 8'h00;
      msk  <= 3'h0;
      tog  <= 6'h00;
    end else begin
      wr_q <= hsel && htrans[1] && hready && hwrite;
      a_q  <= haddr[11:0];
      if (wr_q && a_q == 12'h000) ctrl <= hwdata[7:0];
      if (wr_q && a_q == 12'h00C) msk <= hwdata[2:0];
      if (wr_q && a_q[11:3] == 9'h000) tog <= 6'h00;
      else if ($changed(sclk) && ctrl[5]) tog <= tog + 6'h01;
    end
  end
  property p_oe; $stable(ctrl) |-> sdo_oe == (ctrl[5] && !ctrl[3]); endproperty
  a_oe: assert property (p_oe) else $error("sdo_oe disagrees with control");
  property p_idle; $stable(ctrl) && !ctrl[5] |-> sclk == ctrl[4]; endproperty
  a_idle: assert property (p_idle) else $error("sclk not at idle level");
  property p_go; bw && ctrl[5] && ctrl[1:0] != 2'h3 |-> ##[1:70] $changed(sclk); endproperty
  a_go: assert property (p_go) else $error("buffer write started no clock");
  property p_first; bw && ctrl[5] && !ctrl[3] && sclk == ctrl[4] |=> sdo == $past(hwdata[7]); endproperty
  a_first: assert property (p_first) else $error("first bit not valid before first edge");
  property p_rate4; ctrl[5] && ctrl[1:0] == 2'h0 && $changed(sclk) |=> $stable(sclk); endproperty
  a_rate4: assert property (p_rate4) else $error("clock too fast at divide four");
  property p_rate16; ctrl[5] && ctrl[1:0] == 2'h1 && $changed(sclk) |=> $stable(sclk) [*7]; endproperty
  a_rate16: assert property (p_rate16) else $error("clock too fast at divide sixteen");
  property p_timer;
    ctrl[5] && ctrl[1:0] == 2'h3 && $changed(sclk) |->
      $past(timer_two_tick) || $past(timer_two_tick, 2) || $past(timer_two_tick, 3);
  endproperty
  a_timer: assert property (p_timer) else $error("clock moved without timer pulse");
  property p_irq; $stable(msk) && msk == 3'h0 |-> !irq; endproperty
  a_irq: assert property (p_irq) else $error("interrupt while fully masked");
  property p_count; tog <= 6'd16; endproperty
  a_count: assert property (p_count) else $error("more than sixteen clock edges");
  cover property ($rose(irq));
  cover property (bw && ctrl[1:0] == 2'h3);
  cover property ($changed(sclk) && ctrl[1:0] == 2'h2);
endmodule // spi_master_assertions

bind spi_master_transfer spi_master_assertions chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hwdata, .timer_two_tick, .sclk, .sdo, .sdo_oe, .irq);

// [testbench/spi_slave_model.sv]
// Behavioural SPI slave that answers the master with one byte per frame.
module spi_slave_model (
  // Serial pins.
  input wire logic       sclk,
  input wire logic       sdo,
  output logic           sdi,
  // Frame set-up from the bench.
  input wire logic       load,
  input wire logic       cpha,
  input wire logic [7:0] tx_byte,
  output logic     [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  int edges;
  int k;
  initial begin
    sdi = 1'b0;
    rx_byte = 8'h00;
    edges = 0;
  end
  // There is no select line, so the line is driven to its inverse once the last bit is used up with cpha clear, and at load with cpha set.
  always @(posedge load) begin
    edges = 0;
    sdi = cpha ? ~sdi : tx_byte[7];
  end
  always @(sclk) begin
    edges = edges + 1;
    k = cpha ? (edges - 1) / 2 : edges / 2;
    if (edges <= 16 && edges % 2 == (cpha ? 1 : 0)) sdi = (k < 8) ? tx_byte[7 - k] : ~sdi;
    if (edges <= 16 && edges % 2 == (cpha ? 0 : 1)) rx_byte = {rx_byte[6:0], sdo};
  end
endmodule // spi_slave_model

// [testbench/tb.sv]
// Self-checking bench of the SPI master transfer block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        tick = 1'b0;
  logic        load = 1'b0;
  logic        cpha = 1'b0;
  logic [7:0]  so = 8'h00;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, sclk, sdo, sdo_oe, sdi, irq;
  logic [7:0]  rx;
  logic [31:0] r;
  logic [31:0] seed = 32'd67842;
  int          fails = 0;
  int          n_checks = 0;
  int          st = 0;
  int          msk;
  int          exp_q[$];
  int          adr[4] = '{0, 4, 8, 12};
  always #10 hclk = ~hclk;
  spi_master_transfer dut_u (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .timer_two_tick(tick), .sclk, .sdo, .sdo_oe, .sdi, .irq);
  spi_slave_model slave_u (.sclk, .sdo, .sdi, .load, .cpha, .tx_byte(so), .rx_byte(rx));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  always @(posedge hclk) tick <= xs() % 4 == 0;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic settle();
    repeat (2) @(posedge hclk);
    #1;
  endtask
  task automatic xfer(input int i);
    logic [7:0] ctl;
    logic [7:0] mo;
    logic [7:0] sb;
    ctl = {i[0], i[1], 1'b1, i[2], i == 5, 1'b0, i[2] ^ i[0], i[1] ^ i[0]};
    mo = 8'(xs());
    sb = 8'(xs());
    msk = i[0] ? xs() & 7 : 0;
    bus(1'b1, 12'h00C, msk);
    bus(1'b1, 12'h000, {24'h0, ctl & 8'hDF});
    settle();
    chk("sclk idle", ctl[4], sclk);
    chk("sdo_oe off", 0, sdo_oe);
    bus(1'b1, 12'h000, {24'h0, ctl});
    settle();
    chk("sdo_oe", ctl[5] & ~ctl[3], sdo_oe);
    bus(1'b0, 12'h000, 32'h0);
    chk("control", ctl, r);
    @(posedge hclk);
    cpha <= ~ctl[6];
    so <= sb;
    load <= 1'b1;
    exp_q.push_back(sb);
    bus(1'b1, 12'h004, {24'h0, mo});
    load <= 1'b0;
    do bus(1'b0, 12'h008, 32'h0); while (r[8] !== 1'b0);
    st = (st & 1) ? st | 5 : st | 1;
    bus(1'b0, 12'h004, 32'h0);
    chk("received", exp_q.pop_front(), r);
    if (!ctl[3]) chk("sent", mo, rx);
    bus(1'b0, 12'h008, 32'h0);
    chk("status", st, r);
    chk("irq", (st & msk) != 0, irq);
    chk("sclk end", ctl[4], sclk);
    // One pass leaves the flag set so that the next byte shows an overflow.
    if (i != 2) begin
      bus(1'b1, 12'h008, 32'h7);
      st = 0;
    end
  endtask
  task automatic end_sim();
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (adr[j]) begin
      bus(1'b0, 12'(adr[j]), 32'h0);
      chk("reset value", 0, r);
    end
    bus(1'b1, 12'h010, 32'hFFFFFFFF);
    bus(1'b0, 12'h010, 32'h0);
    chk("unmapped", 0, r);
    for (int i = 0; i < 8; i++) xfer(i);
    end_sim();
  end
endmodule // tb
